//--- hdl/sld_pkg.sv
// package for the smbus lamp dac control block
// assumes one 20 MHz system clock and an asynchronous active-high reset
package sld_pkg;

    // slave address: fixed upper bits, strap picks the lowest bit
    localparam logic [6:0] ADDR_STRAP_LOW  = 7'h2c;  // 58 hex on the wire
    localparam logic [6:0] ADDR_STRAP_HIGH = 7'h2d;  // 5a hex on the wire

    // power-up dac codes per strap level
    localparam logic [5:0] DAC_RESET_LOW   = 6'h00;
    localparam logic [5:0] DAC_RESET_HIGH  = 6'h20;

    // field positions
    localparam int CMD_SUSPEND_BIT = 7;
    localparam int DATA_CODE_MSB   = 7;
    localparam int DATA_CODE_LSB   = 2;

    // bit counter values
    localparam logic [3:0] BIT_ACK = 4'h8;

    // serial line samples after synchronising
    typedef struct packed {
        logic scl;
        logic sda;
    } sld_line_s;

    // transfer phase
    typedef enum logic [2:0] {
        SLD_IDLE,
        SLD_ADDR,
        SLD_CMD,
        SLD_DATA,
        SLD_DONE
    } sld_phase_e;

endpackage

//--- hdl/sld_sync.sv
// two flip-flop synchroniser for the serial pins and the regulator-off and suspend pins
// assumes asynchronous inputs, one sys_clk domain
module sld_sync (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // raw and synchronised levels
    input  wire logic [3:0] raw,
    output logic      [3:0] synced
);

    logic [3:0] stage;

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_bit
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    stage[i]  <= 1'b1;
                    synced[i] <= 1'b1;
                end else begin
                    stage[i]  <= raw[i];
                    synced[i] <= stage[i];
                end
            end
        end
    endgenerate

endmodule // sld_sync

//--- hdl/sld_top.sv
// receive-only smbus slave setting a 6-bit lamp dac code and shutdown state
// assumes external pull-ups on the serial lines, scl slower than sys_clk/8
//
// Functional notes
// [R01] regulator-off low stops regulator; serial and dac logic keep working
// [R02] regulator-off alone leaves stored dac code and dac output unchanged
// [R03] suspend pin low shuts down whole chip including regulator
// [R04] suspend keeps last dac code and restores it when released
// [R05] command byte bit 7 set gives the same suspend as the pin
// [R06] any suspend turns on open-drain pull-down on regulator-off pin
// [R07] strap low: answer address 58 hex, power up at zero scale
// [R08] strap high: answer address 5a hex, power up at half scale
// [R09] host keeps regulator-off low until it has written the wanted code
// [R10] data bits are sampled at rising edges of the serial clock
// [R11] data line released while shifting, pulled low only in acknowledges
// [R12] host writes start, address with write zero, command, data
// [R13] dac code from data bits 7 down to 2, msb first
// [R14] dac code loads at falling edge of the final acknowledge clock
// [R15] stop before the data acknowledge leaves dac code unchanged
// [R16] a non-matching address is neither acknowledged nor acted on
// [R17] regulator runs only with regulator-off high and no suspend
module sld_top (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // serial bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    // control pins
    input  wire logic       addr_strap,
    input  wire logic       regulator_off_n_in,
    output logic            regulator_off_n_out,
    output logic            regulator_off_n_oe_n,
    input  wire logic       suspend_n,
    // regulator and dac side
    output logic            regulator_run,
    output logic            chip_active,
    output logic [5:0]      dac_level
);

    logic [3:0]        synced;
    sld_pkg::sld_line_s line;
    sld_pkg::sld_line_s line_d;
    logic              strap_s;
    logic              reg_off_s;
    logic              susp_s;

    sld_sync u_sync (
        .sys_clk (sys_clk),
        .reset   (reset),
        .raw     ({scl_in, sda_in, regulator_off_n_in, suspend_n}),
        .synced  (synced)
    );

    assign line      = {synced[3], synced[2]};
    assign reg_off_s = synced[1];
    assign susp_s    = synced[0];

    // strap passes its own two flip-flops; no reset, so it settles
    // while reset is held and the power-up code sees its final level
    logic strap_m;
    always_ff @(posedge sys_clk) begin
        strap_m <= addr_strap;
        strap_s <= strap_m;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            line_d <= '1;
        end else begin
            line_d <= line;
        end
    end

    // bus events
    wire scl_rise = line.scl & ~line_d.scl;
    wire scl_fall = ~line.scl & line_d.scl;
    wire start_ev = line.scl & line_d.scl & line_d.sda & ~line.sda;
    wire stop_ev  = line.scl & line_d.scl & ~line_d.sda & line.sda;

    sld_pkg::sld_phase_e phase;
    sld_pkg::sld_phase_e next_phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic       ack_on;
    logic       ack_clk;
    logic       cmd_suspend;
    logic [5:0] code;
    logic       init_done;

    wire [6:0] own_addr = strap_s ? sld_pkg::ADDR_STRAP_HIGH
                                  : sld_pkg::ADDR_STRAP_LOW;       // [R07] [R08]
    wire [5:0] code_def = strap_s ? sld_pkg::DAC_RESET_HIGH
                                  : sld_pkg::DAC_RESET_LOW;        // [R07] [R08]
    wire [7:0] next_shift = {shift[6:0], line.sda};
    wire       byte_in    = scl_rise && bit_cnt == 4'h7;
    wire       addr_ok    = next_shift[7:1] == own_addr
                            && !next_shift[0];                     // [R16]
    wire       in_ack     = bit_cnt == sld_pkg::BIT_ACK;
    // ack_clk marks the ninth clock high, so the fall right after
    // bit 8 opens the acknowledge and only the ninth fall ends it
    wire       ack_end    = scl_fall && in_ack && ack_clk;
    wire       load_code  = ack_end && phase == sld_pkg::SLD_DATA; // [R14]
    wire       load_cmd   = ack_end && phase == sld_pkg::SLD_CMD;
    wire       suspended  = ~susp_s | cmd_suspend;                 // [R03] [R05]

    always_comb begin
        next_phase = phase;
        if (ack_end) begin
            case (phase)
                sld_pkg::SLD_ADDR: next_phase = sld_pkg::SLD_CMD;
                sld_pkg::SLD_CMD:  next_phase = sld_pkg::SLD_DATA;
                sld_pkg::SLD_DATA: next_phase = sld_pkg::SLD_DONE;
                default:           next_phase = phase;
            endcase
        end
        if (byte_in && phase == sld_pkg::SLD_ADDR && !addr_ok) begin
            next_phase = sld_pkg::SLD_IDLE;                         // [R16]
        end
        if (stop_ev) begin
            next_phase = sld_pkg::SLD_IDLE;                         // [R15]
        end
        if (start_ev) begin
            next_phase = sld_pkg::SLD_ADDR;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            phase <= sld_pkg::SLD_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    // bit counter and shifter; bits taken on scl rising edges
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
            ack_clk <= 1'b0;
        end else if (start_ev) begin
            bit_cnt <= 4'h0;
            ack_clk <= 1'b0;
        end else if (scl_rise && !in_ack) begin
            shift   <= next_shift;                                  // [R10]
            bit_cnt <= bit_cnt + 4'h1;
        end else if (scl_rise) begin
            ack_clk <= 1'b1;                                        // [R11]
        end else if (ack_end) begin
            bit_cnt <= 4'h0;
            ack_clk <= 1'b0;
        end
    end

    // acknowledge drive from the low phase after bit 8 to end of ack
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ack_on <= 1'b0;
        end else if (start_ev || stop_ev || ack_end) begin
            ack_on <= 1'b0;                                         // [R11]
        end else if (scl_fall && in_ack && !ack_clk
                     && !ack_on && phase != sld_pkg::SLD_IDLE
                     && phase != sld_pkg::SLD_DONE) begin
            ack_on <= 1'b1;                                         // [R11]
        end
    end

    // command and dac code registers; code loads once strap is settled
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cmd_suspend <= 1'b0;
            code        <= 6'h00;
            init_done   <= 1'b0;
        end else begin
            if (!init_done) begin
                code      <= code_def;                              // [R07] [R08]
                init_done <= 1'b1;
            end else if (load_code) begin
                code <= shift[sld_pkg::DATA_CODE_MSB:
                              sld_pkg::DATA_CODE_LSB];              // [R13] [R14]
            end
            if (load_cmd) begin
                cmd_suspend <= shift[sld_pkg::CMD_SUSPEND_BIT];     // [R05]
            end
        end
    end

    // outputs
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sda_out              <= 1'b0;
            sda_oe_n             <= 1'b1;
            regulator_off_n_out  <= 1'b0;
            regulator_off_n_oe_n <= 1'b1;
            regulator_run        <= 1'b0;
            chip_active          <= 1'b0;
            dac_level            <= 6'h00;
        end else begin
            sda_out              <= 1'b0;
            sda_oe_n             <= ~ack_on;                        // [R11]
            regulator_off_n_out  <= 1'b0;
            regulator_off_n_oe_n <= ~suspended;                     // [R06]
            regulator_run        <= reg_off_s & ~suspended;  // [R01] [R17]
            chip_active          <= ~suspended;                     // [R03]
            dac_level            <= suspended ? 6'h00 : code;// [R02] [R04]
        end
    end

    // checks
    a_code_hold_stop: assert property (@(posedge sys_clk) disable iff (reset)
        init_done && !load_code |=> $stable(code))                  // [R15]
        else $error("dac code changed without data acknowledge");
    a_reg_off_keep: assert property (@(posedge sys_clk) disable iff (reset)
        !reg_off_s && !suspended |=> dac_level == $past(code))      // [R02]
        else $error("dac level lost while regulator off");
    a_run_gate: assert property (@(posedge sys_clk) disable iff (reset)
        regulator_run |-> $past(reg_off_s) && !$past(suspended))    // [R17]
        else $error("regulator running while off or suspended");
    a_reg_stop: assert property (@(posedge sys_clk) disable iff (reset)
        !reg_off_s |=> !regulator_run)                              // [R01]
        else $error("regulator not stopped by regulator-off");
    a_susp_pull: assert property (@(posedge sys_clk) disable iff (reset)
        suspended |=> !regulator_off_n_oe_n && !chip_active)  // [R03] [R06]
        else $error("suspend did not pull regulator-off low");
    a_susp_restore: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(suspended) |=> dac_level == $past(code))              // [R04]
        else $error("dac level not restored after suspend");
    a_ack_only: assert property (@(posedge sys_clk) disable iff (reset)
        !sda_oe_n |-> $past(bit_cnt) == sld_pkg::BIT_ACK)           // [R11]
        else $error("data line driven outside acknowledge");
    a_cmd_susp: assert property (@(posedge sys_clk) disable iff (reset)
        load_cmd && shift[7] |=> ##1 !chip_active)                  // [R05]
        else $error("command suspend bit ignored");
    a_addr_miss: assert property (@(posedge sys_clk) disable iff (reset)
        byte_in && phase == sld_pkg::SLD_ADDR && !addr_ok && !start_ev
        |=> phase == sld_pkg::SLD_IDLE)                             // [R16]
        else $error("foreign address not ignored");
    a_code_load: assert property (@(posedge sys_clk) disable iff (reset)
        load_code && init_done |=> code == $past(shift[7:2]))  // [R13] [R14]
        else $error("dac code not loaded from data byte");

endmodule // sld_top

//--- tb/sld_host.sv
// smbus host model driving write-byte frames on the serial pins
// assumes pull-ups on both lines; scl stands high between frames
module sld_host (
    // clock
    input  wire logic sys_clk,
    // wire level of the data line
    input  wire logic sda_wire,
    // host side of the open-drain lines
    output logic      scl,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // data changes one cycle after scl falls, so no false start or stop
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low <= ~b[i];
            hold(3);
            scl <= 1'b1;
            hold(4);
            scl <= 1'b0;
            hold(1);
        end
        sda_low <= 1'b0;
        hold(3);
        scl <= 1'b1;
        hold(2);
        ack = ~sda_wire;
        hold(2);
        scl <= 1'b0;
        hold(1);
    endtask

    // n bytes sent: 1 address only, 2 adds command, 3 adds data
    task automatic xfer(input logic [7:0] a, input logic [7:0] c,
                        input logic [7:0] d, input int n,
                        output logic [2:0] acks);
        acks = 3'h0;
        sda_low <= 1'b1;
        hold(4);
        scl <= 1'b0;
        hold(1);
        send_byte(a, acks[2]);
        if (n > 1) send_byte(c, acks[1]);
        if (n > 2) send_byte(d, acks[0]);
        sda_low <= 1'b1;
        hold(3);
        scl <= 1'b1;
        hold(4);
        sda_low <= 1'b0;
        hold(8);
    endtask
endmodule // sld_host

//--- tb/sld_top_tb.sv
// self-checking bench for the lamp dac control block
// assumes the host model drives the serial lines; pull-ups on the data and regulator-off lines
module sld_top_tb;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] data;
        logic [5:0] dac;
        logic       act;
    } sld_row_s;

    localparam sld_row_s ROWS [5] = '{
        '{8'h00, 8'hfc, 6'h3f, 1'b1}, '{8'h00, 8'h03, 6'h00, 1'b1},
        '{8'h00, 8'h84, 6'h21, 1'b1}, '{8'h80, 8'h40, 6'h00, 1'b0},
        '{8'h00, 8'h54, 6'h15, 1'b1}};

    logic       sys_clk, reset, addr_strap, suspend_n, off_low;
    logic       scl, host_sda_low, sda_out, sda_oe_n;
    logic       off_out, off_oe_n, regulator_run, chip_active;
    logic [5:0] dac_level;
    logic [2:0] acks;
    int         bad_count, compares, cycles;
    wire logic  sda_wire = host_sda_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);
    wire logic  off_wire = off_low ? 1'b0 : (off_oe_n ? 1'b1 : off_out);

    sld_top u_dut (
        .sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap(addr_strap),
        .regulator_off_n_in(off_wire), .regulator_off_n_out(off_out),
        .regulator_off_n_oe_n(off_oe_n), .suspend_n(suspend_n),
        .regulator_run(regulator_run), .chip_active(chip_active),
        .dac_level(dac_level));

    sld_host u_host (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl),
                     .sda_low(host_sda_low));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic print_verdict();
        $display("mismatches %0d of %0d compares", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic chk1(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask

    task automatic chk6(input logic [5:0] got, input logic [5:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t dac level %h not %h", $time, got, exp);
        end
    endtask

    // suspend shows as chip off, dac off and the pull-down on
    task automatic chk_state(input logic [5:0] dac, input logic act,
                             input logic run);
        @(negedge sys_clk);
        chk6(dac_level, dac);
        chk1(chip_active, act, "chip active");
        chk1(regulator_run, run, "regulator run");
        chk1(off_oe_n, act, "regulator-off pull-down");
        chk1(off_wire, act & ~off_low, "regulator-off pin level");
    endtask

    task automatic apply_reset(input logic strap);
        addr_strap <= strap;
        reset      <= 1'b1;
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (20) @(posedge sys_clk);
    endtask

    initial begin
        reset      = 1'b1;
        addr_strap = 1'b0;
        suspend_n  = 1'b1;
        off_low    = 1'b0;
        apply_reset(1'b0);
        chk_state(sld_pkg::DAC_RESET_LOW, 1'b1, 1'b1);
        u_host.xfer(8'h5a, 8'h00, 8'hfc, 3, acks);
        chk1(acks[2], 1'b0, "foreign address acked");
        chk_state(6'h00, 1'b1, 1'b1);
        foreach (ROWS[i]) begin
            u_host.xfer(8'h58, ROWS[i].cmd, ROWS[i].data, 3, acks);
            chk1(&acks, 1'b1, "byte not acked");
            chk_state(ROWS[i].dac, ROWS[i].act,
                      ROWS[i].act);
        end
        u_host.xfer(8'h58, 8'h00, 8'hfc, 2, acks);
        chk_state(6'h15, 1'b1, 1'b1);
        @(posedge sys_clk) off_low <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk_state(6'h15, 1'b1, 1'b0);
        u_host.xfer(8'h58, 8'h00, 8'hfc, 3, acks);
        chk_state(6'h3f, 1'b1, 1'b0);
        @(posedge sys_clk) off_low <= 1'b0;
        suspend_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk_state(6'h00, 1'b0, 1'b0);
        @(posedge sys_clk) suspend_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk_state(6'h3f, 1'b1, 1'b1);
        apply_reset(1'b1);
        chk_state(sld_pkg::DAC_RESET_HIGH, 1'b1, 1'b1);
        u_host.xfer(8'h58, 8'h00, 8'hfc, 3, acks);
        chk1(acks[2], 1'b0, "foreign address acked");
        u_host.xfer(8'h5a, 8'h00, 8'h0b, 3, acks);
        chk1(&acks, 1'b1, "byte not acked");
        chk_state(6'h02, 1'b1, 1'b1);
        print_verdict();
    end
endmodule // sld_top_tb
